// ### rtl/vis_regs.svh
// Constants for the vectored interrupt priority block
`ifndef VIS_REGS_SVH
`define VIS_REGS_SVH

`define VIS_NUM_SRC 31
`define VIS_NUM_VEC 10
`define VIS_VEC_AW 17
`define VIS_VEC_BASE 17'h00003
`define VIS_VEC_STEP 17'h00008

// Source bits owned by each vector
`define VIS_VEC0_MASK 31'h00000001
`define VIS_VEC1_MASK 31'h00000002
`define VIS_VEC2_MASK 31'h0000003C
`define VIS_VEC3_MASK 31'h000003C0
`define VIS_VEC4_MASK 31'h00000C00
`define VIS_VEC5_MASK 31'h00007000
`define VIS_VEC6_MASK 31'h000F8000
`define VIS_VEC7_MASK 31'h00700000
`define VIS_VEC8_MASK 31'h0F800000
`define VIS_VEC9_MASK 31'h70000000

// Vectors that may take the top level
`define VIS_TOP_CAPABLE 10'h003

// Reset values
`define VIS_FLAGS_RST 31'h00000000
`define VIS_INSVC_RST 3'h0

`endif

// ### rtl/vis_pkg.sv
// Types shared by the vectored interrupt priority block
package vis_pkg;

  // Ordered so that a larger value is a higher level
  typedef enum logic [1:0] {
    VIS_LVL_NONE,
    VIS_LVL_LOW,
    VIS_LVL_HIGH,
    VIS_LVL_TOP
  } vis_level_e;

endpackage

// ### rtl/vis_arbiter.sv
// Level then lowest-vector arbiter
`timescale 1ns/100ps
module vis_arbiter #(
  parameter int NUM_VEC = 10
) (
  input wire logic [NUM_VEC-1:0] elig_top,
  input wire logic [NUM_VEC-1:0] elig_high,
  input wire logic [NUM_VEC-1:0] elig_low,
  output logic gnt_valid,
  output logic [3:0] gnt_index,
  output vis_pkg::vis_level_e gnt_level
);

  if (NUM_VEC < 1 || NUM_VEC > 16)
  begin : g_chk
    $error("vis_arbiter: NUM_VEC must be 1 to 16");
  end

  wire any_top = |elig_top;
  wire any_high = |elig_high;
  wire any_low = |elig_low;

  // Highest level class wins
  wire [NUM_VEC-1:0] cls = any_top ? elig_top : (any_high ? elig_high : elig_low);

  wire [NUM_VEC:0] seen;
  wire [NUM_VEC-1:0] first;
  assign seen[0] = 1'b0;

  // Lowest index within the class wins
  for (genvar i = 0; i < NUM_VEC; i++)
  begin : g_first
    assign first[i] = cls[i] & ~seen[i];
    assign seen[i+1] = seen[i] | cls[i];
  end

  always_comb
  begin
    gnt_index = 4'h0;
    for (int k = 0; k < NUM_VEC; k++)
    begin
      if (first[k])
      begin
        gnt_index = 4'(k);
      end
    end
  end

  assign gnt_valid = any_top | any_high | any_low;
  assign gnt_level = any_top ? vis_pkg::VIS_LVL_TOP :
                     any_high ? vis_pkg::VIS_LVL_HIGH :
                     any_low ? vis_pkg::VIS_LVL_LOW : vis_pkg::VIS_LVL_NONE;

endmodule

// ### rtl/vis_vectored_irq.sv
// Vectored interrupt priority controller top
`timescale 1ns/100ps
`include "vis_regs.svh"

module vis_vectored_irq #(
  parameter int NUM_SRC = `VIS_NUM_SRC,
  parameter int NUM_VEC = `VIS_NUM_VEC
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [NUM_SRC-1:0] src_event,
  input wire logic [NUM_SRC-1:0] src_enable,
  input wire logic [NUM_SRC-1:0] flag_clear,
  input wire logic [NUM_VEC-1:0] level_sel,
  input wire logic irq_ack,
  input wire logic irq_return,
  output logic irq_req,
  output logic [`VIS_VEC_AW-1:0] irq_vector,
  output vis_pkg::vis_level_e irq_level,
  output logic [NUM_SRC-1:0] src_flags,
  output logic [NUM_SRC-1:0] source_flag_list,
  output logic [2:0] in_service
);

  if (NUM_SRC != `VIS_NUM_SRC || NUM_VEC != `VIS_NUM_VEC)
  begin : g_chk
    $error("vis_vectored_irq: source and vector counts are fixed by the map");
  end

  localparam logic [NUM_SRC-1:0] VEC_MASK [NUM_VEC] = '{
    `VIS_VEC0_MASK, `VIS_VEC1_MASK, `VIS_VEC2_MASK, `VIS_VEC3_MASK, `VIS_VEC4_MASK,
    `VIS_VEC5_MASK, `VIS_VEC6_MASK, `VIS_VEC7_MASK, `VIS_VEC8_MASK, `VIS_VEC9_MASK
  };
  localparam logic [NUM_VEC-1:0] TOP_CAPABLE = `VIS_TOP_CAPABLE;

  ////////////////////////////////////////////////////////////////////////////
  // Reset release

  logic rst_meta_r;
  logic rst_n_r;

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Source flags

  logic [NUM_SRC-1:0] flags_r;
  logic [NUM_SRC-1:0] list_r;
  logic [2:0] insvc_r;
  logic req_r;
  logic [3:0] index_r;
  vis_pkg::vis_level_e level_r;

  wire [NUM_SRC-1:0] flags_nxt = (flags_r & ~flag_clear) | src_event;
  wire [NUM_SRC-1:0] live = flags_r & src_enable;

  ////////////////////////////////////////////////////////////////////////////
  // Vector requests and eligibility

  vis_pkg::vis_level_e cur_level;
  assign cur_level = insvc_r[2] ? vis_pkg::VIS_LVL_TOP :
                     insvc_r[1] ? vis_pkg::VIS_LVL_HIGH :
                     insvc_r[0] ? vis_pkg::VIS_LVL_LOW : vis_pkg::VIS_LVL_NONE;

  wire [NUM_VEC-1:0] vec_pend;
  wire [NUM_VEC-1:0] elig_top;
  wire [NUM_VEC-1:0] elig_high;
  wire [NUM_VEC-1:0] elig_low;
  wire may_top = cur_level < vis_pkg::VIS_LVL_TOP;
  wire may_high = cur_level < vis_pkg::VIS_LVL_HIGH;
  wire may_low = cur_level < vis_pkg::VIS_LVL_LOW;

  for (genvar v = 0; v < NUM_VEC; v++)
  begin : g_vec
    assign vec_pend[v] = |(live & VEC_MASK[v]);
    assign elig_top[v] = vec_pend[v] & level_sel[v] & TOP_CAPABLE[v] & may_top;
    assign elig_high[v] = vec_pend[v] & level_sel[v] & ~TOP_CAPABLE[v] & may_high;
    assign elig_low[v] = vec_pend[v] & ~level_sel[v] & may_low;
  end

  wire gnt_valid;
  wire [3:0] gnt_index;
  vis_pkg::vis_level_e gnt_level;

  vis_arbiter #(
    .NUM_VEC(NUM_VEC)
  ) u_arb (
    .elig_top(elig_top),
    .elig_high(elig_high),
    .elig_low(elig_low),
    .gnt_valid(gnt_valid),
    .gnt_index(gnt_index),
    .gnt_level(gnt_level)
  );

  ////////////////////////////////////////////////////////////////////////////
  // In-service stack and branch capture

  wire [2:0] lvl_bit = (level_r == vis_pkg::VIS_LVL_TOP) ? 3'h4 :
                       (level_r == vis_pkg::VIS_LVL_HIGH) ? 3'h2 : 3'h1;
  wire [2:0] top_bit = insvc_r[2] ? 3'h4 : (insvc_r[1] ? 3'h2 : (insvc_r[0] ? 3'h1 : 3'h0));
  wire take = irq_ack & req_r;
  wire [2:0] insvc_nxt = (insvc_r & ~(irq_return ? top_bit : 3'h0)) |
                         (take ? lvl_bit : 3'h0);

  always_ff @(posedge ref_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      flags_r <= `VIS_FLAGS_RST;
      list_r <= `VIS_FLAGS_RST;
      insvc_r <= `VIS_INSVC_RST;
      req_r <= 1'b0;
      index_r <= 4'h0;
      level_r <= vis_pkg::VIS_LVL_NONE;
    end
    else
    begin
      flags_r <= flags_nxt;
      insvc_r <= insvc_nxt;
      list_r <= take ? (live & VEC_MASK[index_r]) : list_r;
      req_r <= gnt_valid & ~irq_ack & ~irq_return;
      index_r <= gnt_index;
      level_r <= gnt_level;
    end
  end

  assign irq_req = req_r;
  assign irq_vector = `VIS_VEC_BASE + `VIS_VEC_AW'(index_r) * `VIS_VEC_STEP;
  assign irq_level = level_r;
  assign src_flags = flags_r;
  assign source_flag_list = list_r;
  assign in_service = insvc_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n_r);

  wire [NUM_VEC-1:0] same_cls = (level_r == vis_pkg::VIS_LVL_TOP) ? elig_top :
                                (level_r == vis_pkg::VIS_LVL_HIGH) ? elig_high : elig_low;
  wire [NUM_VEC-1:0] below_idx = NUM_VEC'((11'h001 << index_r) - 11'h001);

  AST_LEVEL_SET: assert property (req_r |-> level_r != vis_pkg::VIS_LVL_NONE)
    else $error("Request without a level");
  AST_NEST: assert property (req_r |-> level_r > $past(cur_level))
    else $error("Nested request not strictly higher");
  AST_TOP_WINS: assert property ($rose(req_r) |-> !$past(|elig_top)
    || level_r == vis_pkg::VIS_LVL_TOP)
    else $error("Top request lost to a lower level");
  AST_LOWEST: assert property (req_r |-> (((level_r == vis_pkg::VIS_LVL_TOP) ? $past(elig_top) :
    (level_r == vis_pkg::VIS_LVL_HIGH) ? $past(elig_high) : $past(elig_low)) & below_idx) == '0)
    else $error("Lower vector of equal level passed over");
  AST_ADDR: assert property (irq_vector == `VIS_VEC_BASE + 17'(index_r) * 17'h00008)
    else $error("Vector address not base plus eight per index");
  AST_TOP_CAP: assert property (req_r && level_r == vis_pkg::VIS_LVL_TOP |-> index_r < 4'h2)
    else $error("Top level on a vector that cannot take it");
  AST_SHARED: assert property (req_r && irq_vector == 17'h0003B |=> $past(|(flags_r
    & `VIS_VEC7_MASK)))
    else $error("Shared serial vector without its flags");
  AST_LIST: assert property (take |=> source_flag_list == $past(live & VEC_MASK[index_r]))
    else $error("Flag list not captured on branch");
  AST_FLAG_HOLD: assert property (##1 (($past(flags_r) & ~$past(flag_clear)) & ~flags_r) == '0)
    else $error("Flag dropped without a clear");
  AST_SET_WINS: assert property (|src_event |=> (flags_r & $past(src_event)) == $past(src_event))
    else $error("Event lost against a clear");

  COV_BRANCH: cover property (take);
  COV_NEST: cover property (take ##[1:20] take);
  COV_SHARED: cover property (take && index_r == 4'h7 && same_cls[7]);
  COV_RETURN: cover property (irq_return && insvc_r != 3'h0);

endmodule

// ### tb/vis_core_model.sv
// Core model that takes vectored requests and returns from them
`timescale 1ns/100ps
module vis_core_model (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic irq_req,
  input wire logic take_en,
  input wire logic ret_cmd,
  input wire logic [3:0] wait_cyc,
  output logic irq_ack,
  output logic irq_return
);
  logic [3:0] cnt_r;
  logic take_now;
  // Ack only after the request has stood for wait_cyc+1 cycles
  assign take_now = take_en && irq_req && !irq_ack;
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_r <= 4'h0;
      irq_ack <= 1'b0;
      irq_return <= 1'b0;
    end
    else
    begin
      cnt_r <= take_now ? cnt_r + 4'h1 : 4'h0;
      irq_ack <= take_now && (cnt_r >= wait_cyc);
      irq_return <= ret_cmd;
    end
  end
endmodule

// ### tb/vis_vectored_irq_tb_top.sv
// Testbench for the vectored interrupt priority block
`timescale 1ns/100ps
`include "vis_regs.svh"
module vis_vectored_irq_tb_top;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [30:0] src_event = 31'h0;
  logic [30:0] src_enable = 31'h7FFFFFFF;
  logic [30:0] flag_clear = 31'h0;
  logic [9:0] level_sel = 10'h0;
  logic take_en = 1'b0;
  logic ret_cmd = 1'b0;
  logic [3:0] wait_cyc = 4'h0;
  logic irq_ack, irq_return, irq_req;
  logic [16:0] irq_vector;
  vis_pkg::vis_level_e irq_level;
  logic [30:0] src_flags, source_flag_list;
  logic [2:0] in_service;
  int err_total = 0;
  int samples_checked = 0;
  logic [30:0] vm [10] = '{`VIS_VEC0_MASK, `VIS_VEC1_MASK, `VIS_VEC2_MASK, `VIS_VEC3_MASK,
    `VIS_VEC4_MASK, `VIS_VEC5_MASK, `VIS_VEC6_MASK, `VIS_VEC7_MASK, `VIS_VEC8_MASK,
    `VIS_VEC9_MASK};
  always #25 ref_clk = ~ref_clk;
  vis_vectored_irq vis_vectored_irq_inst (.ref_clk, .rstn, .src_event, .src_enable,
    .flag_clear, .level_sel, .irq_ack, .irq_return, .irq_req, .irq_vector, .irq_level,
    .src_flags, .source_flag_list, .in_service);
  vis_core_model vis_core_model_inst (.ref_clk, .rstn, .irq_req, .take_en, .ret_cmd,
    .wait_cyc, .irq_ack, .irq_return);
  ////////////////////////////////////////////////////////////////
  task tally_and_finish;
    if (err_total == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task pulse(input logic [30:0] b);
    @(posedge ref_clk);
    src_event <= b;
    @(posedge ref_clk);
    src_event <= 31'h0;
  endtask
  // Wait for a request, check it, let the core take it
  task take(input int i, input logic [1:0] lv, input logic [30:0] lst, input logic [2:0] svc);
    int n;
    n = 0;
    while (irq_req !== 1'b1 && n < 20)
    begin
      @(negedge ref_clk);
      n++;
    end
    chk(irq_req, 1);
    chk(irq_vector, `VIS_VEC_BASE + 8 * i);
    chk(irq_level, lv);
    @(posedge ref_clk);
    take_en <= 1'b1;
    n = 0;
    while (in_service !== svc && n < 20)
    begin
      @(negedge ref_clk);
      n++;
    end
    @(posedge ref_clk);
    take_en <= 1'b0;
    chk(in_service, svc);
    chk(source_flag_list, lst);
  endtask
  task drop(input logic [30:0] b, input logic [2:0] svc);
    @(posedge ref_clk);
    flag_clear <= b;
    ret_cmd <= 1'b1;
    @(posedge ref_clk);
    flag_clear <= 31'h0;
    ret_cmd <= 1'b0;
    repeat (3) @(negedge ref_clk);
    chk(in_service, svc);
  endtask
  task quiet;
    repeat (4) @(negedge ref_clk);
    chk(irq_req, 0);
  endtask
  ////////////////////////////////////////////////////////////////
  task t_vectors;
    @(posedge ref_clk);
    level_sel <= 10'h3FF;
    for (int i = 0; i < 10; i++)
    begin
      pulse(vm[i]);
      take(i, i < 2 ? vis_pkg::VIS_LVL_TOP : vis_pkg::VIS_LVL_HIGH, vm[i], i < 2 ? 3'h4 : 3'h2);
      drop(vm[i], 3'h0);
    end
  endtask
  task t_order;
    @(posedge ref_clk);
    level_sel <= 10'h0;
    pulse(vm[3] | vm[5]);
    take(3, vis_pkg::VIS_LVL_LOW, vm[3], 3'h1);
    drop(vm[3], 3'h0);
    take(5, vis_pkg::VIS_LVL_LOW, vm[5], 3'h1);
    drop(vm[5], 3'h0);
    @(posedge ref_clk);
    level_sel <= 10'h020;
    wait_cyc <= 4'h3;
    pulse(vm[3] | vm[5]);
    take(5, vis_pkg::VIS_LVL_HIGH, vm[5], 3'h2);
    drop(vm[5], 3'h0);
    take(3, vis_pkg::VIS_LVL_LOW, vm[3], 3'h1);
    drop(vm[3], 3'h0);
  endtask
  task t_nest;
    @(posedge ref_clk);
    level_sel <= 10'h004;
    wait_cyc <= 4'h0;
    pulse(vm[9]);
    take(9, vis_pkg::VIS_LVL_LOW, vm[9], 3'h1);
    pulse(vm[8]);
    quiet;
    pulse(vm[2]);
    take(2, vis_pkg::VIS_LVL_HIGH, vm[2], 3'h3);
    @(posedge ref_clk);
    level_sel <= 10'h005;
    pulse(vm[0]);
    take(0, vis_pkg::VIS_LVL_TOP, vm[0], 3'h7);
    drop(vm[0], 3'h3);
    drop(vm[2], 3'h1);
    quiet;
    drop(vm[9], 3'h0);
    take(8, vis_pkg::VIS_LVL_LOW, vm[8], 3'h1);
    drop(vm[8], 3'h0);
  endtask
  task t_shared;
    @(posedge ref_clk);
    level_sel <= 10'h0;
    src_enable <= 31'h7FBFFFFF;
    pulse(31'h00400000);
    quiet;
    chk(src_flags, 31'h00400000);
    pulse(31'h00300000);
    take(7, vis_pkg::VIS_LVL_LOW, 31'h00300000, 3'h1);
    chk(src_flags, 31'h00700000);
    drop(31'h00700000, 3'h0);
    chk(src_flags, 31'h0);
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk(in_service, 0);
    chk(irq_vector, `VIS_VEC_BASE);
    t_vectors;
    t_order;
    t_nest;
    t_shared;
    tally_and_finish;
  end
  initial
  begin
    #200000;
    err_total++;
    tally_and_finish;
  end
endmodule
